// *** rtl/tws_regs.svh ***
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
// Contract
// - Sample data on rising clock, drive after falling
// - Write guard high protects whole array
// - Sixteen-byte pages, 8 to 11 address bits
// - Data changes only while clock is low
// - Falling data with clock high is start
// - Rising data with clock high is stop
// - Acknowledge each received byte on ninth clock
// - Standby at power-up and after stop
// - Next three bits: zeros or block-select bits
// - Selection word lsb selects read or write
// - Acknowledge matching selection word, otherwise go idle
// - Byte write: selection, address, data, stop
// - Stop launches program cycle, inputs ignored
// - Page write takes up to fifteen more bytes
// - Only low four address bits increment, wrap
// - Poll: acknowledge only after program cycle ends
// - Address counter holds last address plus one
// - Sequential read increments and wraps whole array

// ****************************************
// Protocol constants
// ****************************************
`define TWS_DEV_PATTERN 4'ha
`define TWS_LAST_BIT 4'h7
`define TWS_ACK_BIT 4'h8
`define TWS_FIRST_CNT 4'h1
`define TWS_ADDR_W_DEF 11
`define TWS_ADDR_W_MAX 11
`define TWS_BYTE_W 8
`define TWS_PAGE_BYTES 16
`define TWS_ADDR_ONE 11'h001
`define TWS_LOW_ONE 4'h1

// ****************************************
// Timing
// ****************************************
`define TWS_T_WR_NS 3000000
`define TWS_CLK_NS 20
`endif

// *** rtl/tws_pkg.sv ***
package tws_pkg;
  typedef enum logic [4:0] {
    TWS_IDLE = 5'h01,
    TWS_DEV = 5'h02,
    TWS_WADDR = 5'h04,
    TWS_WDATA = 5'h08,
    TWS_READ = 5'h10
  } tws_state_t;

  // Link side state, clocked by the serial clock
  typedef struct packed {
    tws_state_t st;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] obyte;
    logic [10:0] addr;
    logic [2:0] blk;
    logic [15:0][7:0] page;
    logic [15:0] mask;
    logic armed;
    logic launched;
    logic stop_mark;
    logic start_seen;
    logic [2:0] done_s;
    logic done_seen;
    logic want_low;
  } tws_link_t;

  // Core side state, clocked by sys_clk
  typedef struct packed {
    logic busy;
    logic [17:0] timer;
    logic done_tgl;
    logic in_frame;
    logic stop_seen;
    logic start_seen;
    logic standby;
  } tws_core_t;

  typedef struct packed {
    logic [2:0] s;
    logic q;
  } tws_sync_t;
endpackage

// *** rtl/tws_sync.sv ***
`timescale 1ns/100ps
// Three-stage synchroniser; output follows once stages two and three agree
module tws_sync
  import tws_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  tws_sync_t r;
  tws_sync_t next_r;

  // Stage one feeds only stage two
  always_comb begin
    next_r = r;
    next_r.s = {r.s[1:0], d};
    if (r.s[1] == r.s[2]) begin
      next_r.q = r.s[2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.q;
endmodule

// *** rtl/tws_eeprom.sv ***
`timescale 1ns/100ps
`include "tws_regs.svh"
module tws_eeprom
  import tws_pkg::*;
#(
  parameter int ADDR_W = `TWS_ADDR_W_DEF,
  parameter int WR_CYCLES = `TWS_T_WR_NS / `TWS_CLK_NS
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wp,
  output logic standby
);
  localparam int BLK_W = ADDR_W - `TWS_BYTE_W;
  localparam logic [10:0] ADDR_MASK = 11'((1 << ADDR_W) - 1);

  // ****************************************
  // Storage
  // ****************************************
  // Array is not reset: contents are nonvolatile
  logic [7:0] mem [0:(1 << ADDR_W) - 1];

  tws_link_t sc;
  tws_link_t next_sc;
  tws_core_t sy;
  tws_core_t next_sy;
  logic start_tgl;
  logic stop_tgl;
  logic drive_low;
  logic [7:0] byte_in;
  logic [7:0] rd_byte;
  logic [3:0] sync_in;
  logic [3:0] sync_q;
  logic stop_ev;
  logic start_ev;
  logic prog_go;

  // Selection word decode, shared with the checks
  function automatic logic dev_match(input logic [7:0] b);
    logic [2:0] hi;
    hi = b[3:1] >> BLK_W;
    return (b[7:4] == `TWS_DEV_PATTERN) && (hi == 3'h0);
  endfunction

  // ****************************************
  // Frame markers on the data line
  // ****************************************
  // Data edges while the clock is high mark start and stop; toggles carry
  // them out since the data line is no steady clock
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) begin
      start_tgl <= 1'b0;
    end else if (scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  always_ff @(posedge sda_in or posedge rst) begin
    if (rst) begin
      stop_tgl <= 1'b0;
    end else if (scl) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // ****************************************
  // Link side, serial clock domain
  // ****************************************
  assign byte_in = {sc.shift[6:0], sda_in};
  assign rd_byte = mem[sc.addr[ADDR_W-1:0]];

  // Stop toggle is read only at a start: the clock stands still from the
  // stop until then, so the value is settled when sampled
  always_comb begin
    next_sc = sc;
    next_sc.done_s = {sc.done_s[1:0], sy.done_tgl};
    // Program end counts once the second and third stages agree
    if (sc.done_s[2] == sc.done_s[1] && sc.done_s[2] != sc.done_seen) begin
      next_sc.done_seen = sc.done_s[2];
      next_sc.armed = 1'b0;
      next_sc.launched = 1'b0;
    end
    if (start_tgl != sc.start_seen) begin
      next_sc.start_seen = start_tgl;
      next_sc.stop_mark = stop_tgl;
      next_sc.st = TWS_DEV;
      next_sc.cnt = `TWS_FIRST_CNT;
      next_sc.shift = byte_in;
      next_sc.want_low = 1'b0;
      if (sc.armed && !sc.launched) begin
        if (stop_tgl != sc.stop_mark) begin
          next_sc.launched = 1'b1;
        end
        // Page was handed over at the stop, or a repeated start drops it;
        // a stale armed flag would let a later poll's stop program again
        next_sc.armed = 1'b0;
      end
    end else begin
      case (sc.st)
        TWS_DEV, TWS_WADDR, TWS_WDATA: begin
          if (sc.cnt == `TWS_LAST_BIT) begin
            next_sc.cnt = `TWS_ACK_BIT;
            next_sc.shift = byte_in;
            next_sc.want_low = 1'b1;
            case (sc.st)
              TWS_DEV: begin
                if (!dev_match(byte_in) || sc.launched) begin
                  next_sc.st = TWS_IDLE;
                  next_sc.want_low = 1'b0;
                end else begin
                  next_sc.blk = byte_in[3:1];
                end
              end
              TWS_WADDR: begin
                next_sc.addr = ADDR_MASK & {sc.blk, byte_in};
                next_sc.mask = '0;
                next_sc.st = TWS_WDATA;
              end
              default: begin
                // Guarded writes are still taken in; the core refuses them
                next_sc.page[sc.addr[3:0]] = byte_in;
                next_sc.mask[sc.addr[3:0]] = 1'b1;
                next_sc.armed = 1'b1;
                next_sc.addr[3:0] = sc.addr[3:0] + `TWS_LOW_ONE;
              end
            endcase
          end else if (sc.cnt == `TWS_ACK_BIT) begin
            next_sc.cnt = 4'h0;
            next_sc.want_low = 1'b0;
            if (sc.st == TWS_DEV) begin
              if (sc.shift[0]) begin
                next_sc.st = TWS_READ;
                next_sc.obyte = rd_byte;
                next_sc.addr = ADDR_MASK & (sc.addr + `TWS_ADDR_ONE);
                next_sc.want_low = ~rd_byte[7];
              end else begin
                next_sc.st = TWS_WADDR;
              end
            end
          end else begin
            next_sc.cnt = sc.cnt + `TWS_LOW_ONE;
            next_sc.shift = byte_in;
          end
        end
        TWS_READ: begin
          if (sc.cnt == `TWS_LAST_BIT) begin
            next_sc.cnt = `TWS_ACK_BIT;
            next_sc.want_low = 1'b0; // Release for the controller's answer
          end else if (sc.cnt == `TWS_ACK_BIT) begin
            if (!sda_in) begin
              next_sc.cnt = 4'h0;
              next_sc.obyte = rd_byte;
              next_sc.addr = ADDR_MASK & (sc.addr + `TWS_ADDR_ONE);
              next_sc.want_low = ~rd_byte[7];
            end else begin
              next_sc.st = TWS_IDLE;
              next_sc.want_low = 1'b0;
            end
          end else begin
            next_sc.cnt = sc.cnt + `TWS_LOW_ONE;
            next_sc.obyte = {sc.obyte[6:0], 1'b0};
            next_sc.want_low = ~sc.obyte[6];
          end
        end
        default: begin
          next_sc.want_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      sc <= '{st: TWS_IDLE, default: '0};
    end else begin
      sc <= next_sc;
    end
  end

  // Output changes only after the falling clock edge
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      drive_low <= 1'b0;
    end else begin
      drive_low <= sc.want_low;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = drive_low;

  // ****************************************
  // Core side, sys_clk domain
  // ****************************************
  assign sync_in = {wp, sc.armed, stop_tgl, start_tgl};

  generate
    for (genvar g = 0; g < 4; g++) begin : g_sync
      tws_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(sync_in[g]),
        .q(sync_q[g])
      );
    end
  endgenerate

  assign stop_ev = sync_q[1] != sy.stop_seen;
  assign start_ev = sync_q[0] != sy.start_seen;
  assign prog_go = stop_ev && sync_q[2] && !sy.busy;

  // The page buffer is read only while the link clock is parked after the
  // stop and armed holds it, so its contents are steady here
  always_comb begin
    next_sy = sy;
    next_sy.stop_seen = sync_q[1];
    next_sy.start_seen = sync_q[0];
    if (stop_ev) begin
      next_sy.in_frame = 1'b0;
    end
    if (start_ev) begin
      next_sy.in_frame = 1'b1;
    end
    if (prog_go) begin
      if (sync_q[3]) begin
        next_sy.done_tgl = ~sy.done_tgl;
      end else begin
        next_sy.busy = 1'b1;
        next_sy.timer = 18'(WR_CYCLES - 1);
      end
    end else if (sy.busy) begin
      if (sy.timer == '0) begin
        next_sy.busy = 1'b0;
        next_sy.done_tgl = ~sy.done_tgl;
      end else begin
        next_sy.timer = sy.timer - 18'h1;
      end
    end
    next_sy.standby = !next_sy.in_frame && !next_sy.busy;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sy <= '{standby: 1'b1, default: '0};
    end else begin
      sy <= next_sy;
    end
  end

  // Whole page committed at once; only bytes received this frame change
  always_ff @(posedge sys_clk) begin
    if (prog_go && !sync_q[3]) begin
      for (int i = 0; i < `TWS_PAGE_BYTES; i++) begin
        if (sc.mask[i]) begin
          mem[{sc.addr[ADDR_W-1:4], 4'(i)}] <= sc.page[i];
        end
      end
    end
  end

  assign standby = sy.standby;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_dev_done;
    sc.st == TWS_DEV && sc.cnt == `TWS_LAST_BIT && start_tgl == sc.start_seen;
  endsequence

  sequence s_data_done;
    sc.st == TWS_WDATA && sc.cnt == `TWS_LAST_BIT && start_tgl == sc.start_seen;
  endsequence

  dev_ack_a: assert property (@(posedge scl) disable iff (rst)
    s_dev_done and (dev_match(byte_in) && !sc.launched) |=> sda_oe ##1 !sda_oe || sc.st == TWS_READ)
    else $error("matching selection word not acknowledged");

  dev_nack_a: assert property (@(posedge scl) disable iff (rst)
    s_dev_done and !dev_match(byte_in) |=> !sda_oe && sc.st == TWS_IDLE)
    else $error("foreign selection word acknowledged");

  poll_nack_a: assert property (@(posedge scl) disable iff (rst)
    s_dev_done and sc.launched |=> !sda_oe)
    else $error("selection acknowledged during program cycle");

  data_ack_a: assert property (@(posedge scl) disable iff (rst)
    s_data_done |=> sda_oe ##1 !sda_oe)
    else $error("data byte acknowledge missing or held");

  page_wrap_a: assert property (@(posedge scl) disable iff (rst)
    s_data_done |=> sc.addr[10:4] == $past(sc.addr[10:4]) && sc.addr[3:0] == $past(sc.addr[3:0]) + 4'h1)
    else $error("write address left its page");

  start_seen_a: assert property (@(posedge scl) disable iff (rst)
    start_tgl != sc.start_seen |=> sc.st == TWS_DEV && sc.cnt == `TWS_FIRST_CNT)
    else $error("start did not open a selection word");

  read_inc_a: assert property (@(posedge scl) disable iff (rst)
    sc.st == TWS_READ && sc.cnt == `TWS_ACK_BIT && !sda_in && start_tgl == sc.start_seen
    |=> sc.addr == (ADDR_MASK & ($past(sc.addr) + `TWS_ADDR_ONE)))
    else $error("read address did not advance");

  prog_len_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(sy.busy) |-> sy.busy [*8])
    else $error("program cycle ended too early");

  prog_end_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(sy.busy) |-> sy.done_tgl != $past(sy.done_tgl))
    else $error("program end not signalled");

  guard_a: assert property (@(posedge sys_clk) disable iff (rst)
    prog_go && sync_q[3] |=> !sy.busy)
    else $error("guarded write started a program cycle");

  standby_a: assert property (@(posedge sys_clk) disable iff (rst)
    sy.busy |-> !standby)
    else $error("standby shown during program cycle");
endmodule

// *** testbench/tws_ctl.sv ***
`timescale 1ns/100ps
// Bus controller model; scl stands high between frames
module tws_ctl
  import tws_pkg::*;
(
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  localparam int HALF = 24;
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Clock out a stuck transfer, stop once data reads high
  task automatic recover();
    sda_oe = 1'b0;
    for (int i = 0; i < 9; i++) begin
      #HALF scl = 1'b0;
      #HALF scl = 1'b1;
      if (sda === 1'b1) break;
    end
    #HALF;
  endtask
  // Start, also used as repeated start
  task automatic start();
    sda_oe = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_oe = 1'b1;
    #HALF scl = 1'b0;
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    sda_oe = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_oe = 1'b0;
    #HALF;
  endtask
  // One bit: data moves only while clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    #HALF scl = 1'b1;
    r = sda;
    #HALF scl = 1'b0;
  endtask
  // Byte out, msb first; ack returned as 1 when the line was pulled low
  task automatic wbyte(input logic [7:0] d, output logic [7:0] ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = {7'h0, ~r};
  endtask
  // Byte in; a high ninth bit ends a read
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nak, r);
  endtask
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/100ps
module tb;
  logic sys_clk;
  logic rst;
  logic wp = 1'b0;
  logic scl, sda, dev_out, dev_oe, ctl_oe, standby;
  logic [31:0] lfsr_state = 32'h7666;
  logic [7:0] mem [0:2047];
  bit known [0:2047];
  logic [10:0] cur = 11'h0;
  int failures = 0;
  int samples_checked = 0;

  // Open-drain line with pull-up
  assign sda = ~((dev_oe & ~dev_out) | ctl_oe);
  // Shortened program cycle, still long enough to refuse a first poll
  tws_eeprom #(.ADDR_W(11), .WR_CYCLES(64)) tws_eeprom_inst (
    .sys_clk(sys_clk), .rst(rst), .scl(scl), .sda_in(sda),
    .sda_out(dev_out), .sda_oe(dev_oe), .wp(wp), .standby(standby)
  );
  tws_ctl tws_ctl_inst (.scl(scl), .sda_oe(ctl_oe), .sda(sda));
  // 50 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ********
  // Helpers
  // ********
  function automatic logic [31:0] rnd();
    lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    return lfsr_state;
  endfunction
  // Selection word: fixed pattern, block bits, direction
  function automatic logic [7:0] sel_word(input logic [10:0] a, input logic rd);
    return {4'ha, a[10:8], rd};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bounded wait for standby, then the idle gap a new start needs
  task automatic wait_idle();
    int n;
    n = 0;
    while (standby !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 400) begin
      failures++;
      close_out();
    end
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic addr_phase(input logic [10:0] a);
    logic [7:0] ack;
    tws_ctl_inst.start();
    tws_ctl_inst.wbyte(sel_word(a, 1'b0), ack);
    check(ack, 8'h01);
    tws_ctl_inst.wbyte(a[7:0], ack);
    check(ack, 8'h01);
  endtask
  // First poll lands inside the program cycle and must be refused
  task automatic poll(input logic [10:0] a);
    logic [7:0] ack;
    int n;
    n = 0;
    do begin
      repeat (7) @(posedge sys_clk);
      tws_ctl_inst.start();
      tws_ctl_inst.wbyte(sel_word(a, 1'b0), ack);
      tws_ctl_inst.stop();
      if (n == 0) check(ack, 8'h00);
      n++;
    end while (ack !== 8'h01 && n < 20);
    check(ack, 8'h01);
    if (ack !== 8'h01) close_out();
  endtask
  // Write n random bytes; model wraps inside the page
  task automatic write_seq(input logic [10:0] a, input int n);
    logic [7:0] ack;
    logic [7:0] d;
    logic [10:0] w;
    addr_phase(a);
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      w = {a[10:4], a[3:0] + i[3:0]};
      tws_ctl_inst.wbyte(d, ack);
      check(ack, 8'h01);
      if (!wp) begin
        mem[w] = d;
        known[w] = 1'b1;
      end
    end
    tws_ctl_inst.stop();
    repeat (7) @(posedge sys_clk);
    check({7'h0, standby}, {7'h0, wp});
    if (!wp) poll(a);
    wait_idle();
  endtask
  // Read n bytes, from a (random) or from the internal counter
  task automatic read_seq(input logic [10:0] a, input int n, input logic set);
    logic [7:0] ack;
    logic [7:0] d;
    if (set) begin
      addr_phase(a);
      cur = a;
    end
    tws_ctl_inst.start();
    tws_ctl_inst.wbyte(sel_word(cur, 1'b1), ack);
    check(ack, 8'h01);
    for (int i = 0; i < n; i++) begin
      tws_ctl_inst.rbyte(i == n - 1, d);
      if (known[cur]) check(d, mem[cur]);
      cur = cur + 11'h1;
    end
    tws_ctl_inst.stop();
    wait_idle();
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    logic [31:0] r;
    logic [7:0] ack;
    logic [7:0] bad [0:2];
    bad = '{8'h20, 8'hb0, 8'he1};
    // Reset raised by an edge, so the link flops clear asynchronously
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check({7'h0, standby}, 8'h01);
    tws_ctl_inst.recover();
    $display("test reset done");
    r = rnd();
    write_seq(r[10:0], 1);
    read_seq(r[10:0], 1, 1'b1);
    $display("test byte write done");
    // Random pages and lengths, more than sixteen bytes overwrite
    for (int k = 0; k < 3; k++) begin
      r = rnd();
      write_seq(r[10:0], int'(r[15:11]) % 20 + 1);
      read_seq({r[10:4], 4'h0}, 16, 1'b1);
    end
    $display("test page write done");
    // Read across the top of the array, then a current read
    write_seq(11'h7ff, 1);
    write_seq(11'h000, 3);
    read_seq(11'h7ff, 3, 1'b1);
    read_seq(11'h000, 1, 1'b0);
    $display("test wrap read done");
    // Guarded write is acked but leaves the old byte
    wp <= 1'b1;
    repeat (6) @(posedge sys_clk);
    write_seq(11'h001, 1);
    read_seq(11'h001, 1, 1'b1);
    wp <= 1'b0;
    $display("test guard done");
    // Wrong pattern: no ack, later words ignored until a new start
    for (int k = 0; k < 3; k++) begin
      tws_ctl_inst.start();
      tws_ctl_inst.wbyte(bad[k], ack);
      check(ack, 8'h00);
      tws_ctl_inst.wbyte(8'ha0, ack);
      check(ack, 8'h00);
      tws_ctl_inst.stop();
      wait_idle();
    end
    $display("test bad selection done");
    close_out();
  end
endmodule
